// ### rtl/bfc_map.svh
`ifndef BFC_MAP_SVH
`define BFC_MAP_SVH
// ==========================================================
// Widths
`define BFC_PC_W        16
`define BFC_OFS_W       12
`define BFC_PC_RST      16'h0000
// ==========================================================
// Status flag byte bit positions
`define BFC_FLG_C       3'h0
`define BFC_FLG_Z       3'h1
`define BFC_FLG_N       3'h2
`define BFC_FLG_V       3'h3
`define BFC_FLG_S       3'h4
`define BFC_FLG_H       3'h5
`define BFC_FLG_T       3'h6
`define BFC_FLG_I       3'h7
// ==========================================================
// Cycle counts
`define BFC_CYC_ONE     3'h1
`define BFC_CYC_REL_JMP 3'h2
`define BFC_CYC_PTR_JMP 3'h2
`define BFC_CYC_ABS_JMP 3'h3
`define BFC_CYC_REL_INV 3'h3
`define BFC_CYC_PTR_INV 3'h3
`define BFC_CYC_ABS_INV 3'h4
`define BFC_CYC_EXIT    3'h4
`define BFC_CYC_BR_TAKE 3'h2
`define BFC_CYC_SKIP1   3'h2
`define BFC_CYC_SKIP2   3'h3
// Program counter steps
`define BFC_STEP_ONE    16'h0001
`define BFC_STEP_TWO    16'h0002
`define BFC_STEP_THREE  16'h0003
`endif

// ### rtl/bfc_pkg.sv
package bfc_pkg;
  typedef enum logic [5:0] {
    BFC_OP_STEP                    = 6'h00,
    BFC_OP_RELATIVE_JUMP           = 6'h01,
    BFC_OP_POINTER_JUMP            = 6'h02,
    BFC_OP_ABSOLUTE_JUMP           = 6'h03,
    BFC_OP_RELATIVE_SUB_INVOKE     = 6'h04,
    BFC_OP_POINTER_SUB_INVOKE      = 6'h05,
    BFC_OP_ABSOLUTE_SUB_INVOKE     = 6'h06,
    BFC_OP_SUBROUTINE_EXIT         = 6'h07,
    BFC_OP_INTERRUPT_EXIT          = 6'h08,
    BFC_OP_COMPARE_SKIP_EQUAL      = 6'h09,
    BFC_OP_COMPARE_REGISTERS       = 6'h0A,
    BFC_OP_COMPARE_WITH_BORROW     = 6'h0B,
    BFC_OP_COMPARE_IMMEDIATE       = 6'h0C,
    BFC_OP_SKIP_REG_BIT_CLEAR      = 6'h0D,
    BFC_OP_SKIP_REG_BIT_SET        = 6'h0E,
    BFC_OP_SKIP_IO_BIT_CLEAR       = 6'h0F,
    BFC_OP_SKIP_IO_BIT_SET         = 6'h10,
    BFC_OP_BRANCH_FLAG_SET         = 6'h11,
    BFC_OP_BRANCH_FLAG_CLEAR       = 6'h12,
    BFC_OP_BRANCH_EQUAL            = 6'h13,
    BFC_OP_BRANCH_NOT_EQUAL        = 6'h14,
    BFC_OP_BRANCH_CARRY_SET        = 6'h15,
    BFC_OP_BRANCH_CARRY_CLEAR      = 6'h16,
    BFC_OP_BRANCH_SAME_OR_HIGHER   = 6'h17,
    BFC_OP_BRANCH_LOWER            = 6'h18,
    BFC_OP_BRANCH_MINUS            = 6'h19,
    BFC_OP_BRANCH_PLUS             = 6'h1A,
    BFC_OP_BRANCH_SIGNED_GE        = 6'h1B,
    BFC_OP_BRANCH_SIGNED_LESS      = 6'h1C,
    BFC_OP_BRANCH_HALF_CARRY_SET   = 6'h1D,
    BFC_OP_BRANCH_HALF_CARRY_CLEAR = 6'h1E,
    BFC_OP_BRANCH_TRANSFER_SET     = 6'h1F,
    BFC_OP_BRANCH_TRANSFER_CLEAR   = 6'h20,
    BFC_OP_BRANCH_OVERFLOW_SET     = 6'h21,
    BFC_OP_BRANCH_OVERFLOW_CLEAR   = 6'h22,
    BFC_OP_BRANCH_IRQ_ENABLED      = 6'h23,
    BFC_OP_BRANCH_IRQ_DISABLED     = 6'h24
  } bfc_op_e;

  typedef enum logic [1:0] {
    BFC_ST_IDLE = 2'b01,
    BFC_ST_WAIT = 2'b10
  } bfc_state_e;
endpackage : bfc_pkg

// ### rtl/bfc_compare.sv
`timescale 1ns/100ps
`default_nettype none
`include "bfc_map.svh"
// ==========================================================
// Subtract without result, returns updated status flag byte
module bfc_compare (
  input  wire logic [7:0] opa,        // Minuend register
  input  wire logic [7:0] opb,        // Subtrahend register or constant
  input  wire logic       with_carry, // Also subtract carry
  input  wire logic [7:0] status_in,  // Current status flag byte
  output logic      [7:0] status_out  // Status byte with new flags
);
  logic [8:0] diff;
  logic       cin;
  logic [7:0] r;

  always_comb
  begin
    cin  = with_carry & status_in[`BFC_FLG_C];
    diff = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
    r    = diff[7:0];
    status_out = status_in;
    status_out[`BFC_FLG_C] = diff[8];
    // Chained compare keeps zero only if all bytes were zero
    status_out[`BFC_FLG_Z] = (r == 8'h00) & (with_carry ? status_in[`BFC_FLG_Z] : 1'b1);
    status_out[`BFC_FLG_N] = r[7];
    status_out[`BFC_FLG_V] = (opa[7] & ~opb[7] & ~r[7]) | (~opa[7] & opb[7] & r[7]);
    status_out[`BFC_FLG_S] = r[7] ^ status_out[`BFC_FLG_V];
    status_out[`BFC_FLG_H] = (~opa[3] & opb[3]) | (opb[3] & r[3]) | (r[3] & ~opa[3]);
  end
endmodule : bfc_compare
`default_nettype wire

// ### rtl/bfc_cond.sv
`timescale 1ns/100ps
`default_nettype none
`include "bfc_map.svh"
// ==========================================================
// Skip and branch condition evaluation
module bfc_cond (
  input  wire bfc_pkg::bfc_op_e op,        // Operation being issued
  input  wire logic [7:0]       opa,       // First register value
  input  wire logic [7:0]       opb,       // Second register value
  input  wire logic [7:0]       io_byte,   // Addressed I/O register value
  input  wire logic [2:0]       bit_sel,   // Bit or flag index
  input  wire logic [7:0]       status_in, // Status flag byte
  output logic                  take       // Skip or branch condition met
);
  logic c, z, n, v, h, t, i;

  always_comb
  begin
    c = status_in[`BFC_FLG_C];
    z = status_in[`BFC_FLG_Z];
    n = status_in[`BFC_FLG_N];
    v = status_in[`BFC_FLG_V];
    h = status_in[`BFC_FLG_H];
    t = status_in[`BFC_FLG_T];
    i = status_in[`BFC_FLG_I];
    unique case (op)
      bfc_pkg::BFC_OP_COMPARE_SKIP_EQUAL:      take = (opa == opb);
      bfc_pkg::BFC_OP_SKIP_REG_BIT_CLEAR:      take = ~opa[bit_sel];
      bfc_pkg::BFC_OP_SKIP_REG_BIT_SET:        take = opa[bit_sel];
      bfc_pkg::BFC_OP_SKIP_IO_BIT_CLEAR:       take = ~io_byte[bit_sel];
      bfc_pkg::BFC_OP_SKIP_IO_BIT_SET:         take = io_byte[bit_sel];
      bfc_pkg::BFC_OP_BRANCH_FLAG_SET:         take = status_in[bit_sel];
      bfc_pkg::BFC_OP_BRANCH_FLAG_CLEAR:       take = ~status_in[bit_sel];
      bfc_pkg::BFC_OP_BRANCH_EQUAL:            take = z;
      bfc_pkg::BFC_OP_BRANCH_NOT_EQUAL:        take = ~z;
      bfc_pkg::BFC_OP_BRANCH_CARRY_SET:        take = c;
      bfc_pkg::BFC_OP_BRANCH_LOWER:            take = c;
      bfc_pkg::BFC_OP_BRANCH_CARRY_CLEAR:      take = ~c;
      bfc_pkg::BFC_OP_BRANCH_SAME_OR_HIGHER:   take = ~c;
      bfc_pkg::BFC_OP_BRANCH_SIGNED_GE:        take = ~(n ^ v);
      bfc_pkg::BFC_OP_BRANCH_SIGNED_LESS:      take = n ^ v;
      bfc_pkg::BFC_OP_BRANCH_OVERFLOW_SET:     take = v;
      bfc_pkg::BFC_OP_BRANCH_OVERFLOW_CLEAR:   take = ~v;
      bfc_pkg::BFC_OP_BRANCH_MINUS:            take = n;
      bfc_pkg::BFC_OP_BRANCH_PLUS:             take = ~n;
      bfc_pkg::BFC_OP_BRANCH_HALF_CARRY_SET:   take = h;
      bfc_pkg::BFC_OP_BRANCH_HALF_CARRY_CLEAR: take = ~h;
      bfc_pkg::BFC_OP_BRANCH_TRANSFER_SET:     take = t;
      bfc_pkg::BFC_OP_BRANCH_TRANSFER_CLEAR:   take = ~t;
      bfc_pkg::BFC_OP_BRANCH_IRQ_ENABLED:      take = i;
      bfc_pkg::BFC_OP_BRANCH_IRQ_DISABLED:     take = ~i;
      default:                                 take = 1'b0;
    endcase
  end
endmodule : bfc_cond
`default_nettype wire

// ### rtl/bfc_flow_unit.sv
// Operation
// - Relative jump PC+k+1 in 2, pointer jump Z in 2, absolute 3.
// - Calls push return address; relative/pointer 3 cycles, absolute 4, return 4.
// - Compare-skip-equal skips next instruction when equal; 1/2/3 cycles, no flags.
// - Compares subtract without storing; update Z,N,V,S,C,H in one cycle.
// - Register bit skip on clear or set, taking 1/2/3 cycles.
// - I/O bit skip on clear or set, taking 1/2/3 cycles.
// - Generic branch tests chosen status bit; PC+k+1; 1 or 2 cycles.
// - Equal branch on Z=1, not-equal on Z=0.
// - Carry set/lower on C=1, carry clear/same-or-higher on C=0.
// - Signed branches test N xor V: ge on 0, less on 1.
// - Overflow branches test V; minus/plus test N.
// - Half-carry branches test H; no flags changed; 1 or 2 cycles.
// - Transfer-bit branches test T; PC+k+1 when taken.
// - Interrupt-enable branches test I; 1 or 2 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "bfc_map.svh"
module bfc_flow_unit (
  input  wire logic                  clock,         // Core clock, 50 MHz
  input  wire logic                  rst_n,         // Synchronous reset, active low
  input  wire logic                  issue_valid,   // Instruction offered
  input  wire bfc_pkg::bfc_op_e      issue_op,      // Decoded operation
  input  wire logic [`BFC_OFS_W-1:0] issue_offset,  // Signed relative offset
  input  wire logic [`BFC_PC_W-1:0]  issue_addr,    // Absolute target address
  input  wire logic [`BFC_PC_W-1:0]  z_ptr,         // Z pointer value
  input  wire logic [7:0]            operand_a,     // First register value
  input  wire logic [7:0]            operand_b,     // Second register or constant
  input  wire logic [7:0]            io_byte,       // Addressed I/O register value
  input  wire logic [2:0]            bit_sel,       // Bit or flag index
  input  wire logic [7:0]            status_in,     // Status flag byte
  input  wire logic                  next_two_word, // Following instruction is two words
  input  wire logic [`BFC_PC_W-1:0]  stack_rdata,   // Popped return address
  output logic                       issue_ready,   // Ready to take an instruction
  output logic      [`BFC_PC_W-1:0]  pc,            // Program counter
  output logic                       done,          // Instruction completed pulse
  output logic                       flag_we,       // Status byte write pulse
  output logic      [7:0]            flag_out,      // New status flag byte
  output logic                       push,          // Push return address pulse
  output logic      [`BFC_PC_W-1:0]  push_data,     // Return address to push
  output logic                       pop            // Pop return address pulse
);
  // ==========================================================
  // Helpers
  function automatic logic [`BFC_PC_W-1:0] rel_target(
    input logic [`BFC_PC_W-1:0]  base,
    input logic [`BFC_OFS_W-1:0] ofs
  );
    logic [`BFC_PC_W-1:0] sext;
    sext = {{(`BFC_PC_W-`BFC_OFS_W){ofs[`BFC_OFS_W-1]}}, ofs};
    return base + sext + `BFC_STEP_ONE;
  endfunction : rel_target

  function automatic logic is_branch(input bfc_pkg::bfc_op_e op);
    return (op >= bfc_pkg::BFC_OP_BRANCH_FLAG_SET) && (op <= bfc_pkg::BFC_OP_BRANCH_IRQ_DISABLED);
  endfunction : is_branch

  function automatic logic is_skip(input bfc_pkg::bfc_op_e op);
    return (op == bfc_pkg::BFC_OP_COMPARE_SKIP_EQUAL) ||
           ((op >= bfc_pkg::BFC_OP_SKIP_REG_BIT_CLEAR) && (op <= bfc_pkg::BFC_OP_SKIP_IO_BIT_SET));
  endfunction : is_skip

  function automatic logic is_exit(input bfc_pkg::bfc_op_e op);
    return (op == bfc_pkg::BFC_OP_SUBROUTINE_EXIT) || (op == bfc_pkg::BFC_OP_INTERRUPT_EXIT);
  endfunction : is_exit

  // ==========================================================
  // State
  bfc_pkg::bfc_state_e       state_q;
  logic [1:0]                cnt_q;
  logic [`BFC_PC_W-1:0]      pc_q;
  logic [`BFC_PC_W-1:0]      tgt_q;
  logic                      exit_q;
  logic                      irq_exit_q;
  logic                      ready_q;
  logic                      done_q;
  logic                      flag_we_q;
  logic [7:0]                flag_q;
  logic                      push_q;
  logic [`BFC_PC_W-1:0]      push_data_q;
  logic                      pop_q;

  logic                      accept;
  logic                      fin;
  logic                      take;
  logic [7:0]                cmp_status;
  logic [`BFC_PC_W-1:0]      tgt_d;
  logic [2:0]                cyc_d;
  logic                      push_d;
  logic [`BFC_PC_W-1:0]      ret_d;
  logic [`BFC_PC_W-1:0]      fin_pc;

  // ==========================================================
  // Condition and compare units
  bfc_cond u_cond (
    .op        (issue_op),
    .opa       (operand_a),
    .opb       (operand_b),
    .io_byte   (io_byte),
    .bit_sel   (bit_sel),
    .status_in (status_in),
    .take      (take)
  );

  bfc_compare u_compare (
    .opa        (operand_a),
    .opb        (operand_b),
    .with_carry (issue_op == bfc_pkg::BFC_OP_COMPARE_WITH_BORROW),
    .status_in  (status_in),
    .status_out (cmp_status)
  );

  // ==========================================================
  // Decode: target, cycle count, stack push
  always_comb
  begin
    tgt_d  = pc_q + `BFC_STEP_ONE;
    cyc_d  = `BFC_CYC_ONE;
    push_d = 1'b0;
    ret_d  = pc_q + `BFC_STEP_ONE;
    if (is_branch(issue_op))
    begin
      if (take)
      begin
        tgt_d = rel_target(pc_q, issue_offset);
        cyc_d = `BFC_CYC_BR_TAKE;
      end
    end
    else if (is_skip(issue_op))
    begin
      if (take)
      begin
        tgt_d = pc_q + (next_two_word ? `BFC_STEP_THREE : `BFC_STEP_TWO);
        cyc_d = next_two_word ? `BFC_CYC_SKIP2 : `BFC_CYC_SKIP1;
      end
    end
    else
    begin
      unique case (issue_op)
        bfc_pkg::BFC_OP_RELATIVE_JUMP:
        begin
          tgt_d = rel_target(pc_q, issue_offset);
          cyc_d = `BFC_CYC_REL_JMP;
        end
        bfc_pkg::BFC_OP_POINTER_JUMP:
        begin
          tgt_d = z_ptr;
          cyc_d = `BFC_CYC_PTR_JMP;
        end
        bfc_pkg::BFC_OP_ABSOLUTE_JUMP:
        begin
          tgt_d = issue_addr;
          cyc_d = `BFC_CYC_ABS_JMP;
        end
        bfc_pkg::BFC_OP_RELATIVE_SUB_INVOKE:
        begin
          tgt_d  = rel_target(pc_q, issue_offset);
          cyc_d  = `BFC_CYC_REL_INV;
          push_d = 1'b1;
        end
        bfc_pkg::BFC_OP_POINTER_SUB_INVOKE:
        begin
          tgt_d  = z_ptr;
          cyc_d  = `BFC_CYC_PTR_INV;
          push_d = 1'b1;
        end
        bfc_pkg::BFC_OP_ABSOLUTE_SUB_INVOKE:
        begin
          // Two-word instruction, so return past the address word
          tgt_d  = issue_addr;
          cyc_d  = `BFC_CYC_ABS_INV;
          push_d = 1'b1;
          ret_d  = pc_q + `BFC_STEP_TWO;
        end
        bfc_pkg::BFC_OP_SUBROUTINE_EXIT,
        bfc_pkg::BFC_OP_INTERRUPT_EXIT:
        begin
          cyc_d = `BFC_CYC_EXIT;
        end
        default:
        begin
          cyc_d = `BFC_CYC_ONE;
        end
      endcase
    end
  end

  assign accept = issue_valid && ready_q;
  assign fin    = (accept && (cyc_d == `BFC_CYC_ONE)) ||
                  ((state_q == bfc_pkg::BFC_ST_WAIT) && (cnt_q == 2'h0));
  // Returns take the popped address in their last cycle
  assign fin_pc = exit_q ? stack_rdata : ((state_q == bfc_pkg::BFC_ST_WAIT) ? tgt_q : tgt_d);

  // ==========================================================
  // Cycle sequencer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q <= bfc_pkg::BFC_ST_IDLE;
      cnt_q   <= 2'h0;
      ready_q <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        bfc_pkg::BFC_ST_IDLE:
        begin
          if (accept && (cyc_d != `BFC_CYC_ONE))
          begin
            state_q <= bfc_pkg::BFC_ST_WAIT;
            cnt_q   <= 2'(cyc_d - 3'h2);
            ready_q <= 1'b0;
          end
        end
        bfc_pkg::BFC_ST_WAIT:
        begin
          if (cnt_q == 2'h0)
          begin
            state_q <= bfc_pkg::BFC_ST_IDLE;
            ready_q <= 1'b1;
          end
          else
          begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Target capture
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tgt_q      <= `BFC_PC_RST;
      exit_q     <= 1'b0;
      irq_exit_q <= 1'b0;
    end
    else if (accept)
    begin
      tgt_q      <= tgt_d;
      exit_q     <= is_exit(issue_op);
      irq_exit_q <= (issue_op == bfc_pkg::BFC_OP_INTERRUPT_EXIT);
    end
    else if (fin)
    begin
      exit_q     <= 1'b0;
      irq_exit_q <= 1'b0;
    end
  end

  // ==========================================================
  // Program counter and completion
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pc_q   <= `BFC_PC_RST;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= fin;
      if (fin)
      begin
        pc_q <= fin_pc;
      end
    end
  end

  // ==========================================================
  // Stack traffic
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      push_q      <= 1'b0;
      push_data_q <= `BFC_PC_RST;
      pop_q       <= 1'b0;
    end
    else
    begin
      push_q <= accept && push_d;
      pop_q  <= accept && is_exit(issue_op);
      if (accept && push_d)
      begin
        push_data_q <= ret_d;
      end
    end
  end

  // ==========================================================
  // Status flag writes
  // Branches and skips never write flags, so status stays with the owner
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      flag_we_q <= 1'b0;
      flag_q    <= 8'h00;
    end
    else
    begin
      flag_we_q <= 1'b0;
      if (accept && ((issue_op == bfc_pkg::BFC_OP_COMPARE_REGISTERS) ||
                     (issue_op == bfc_pkg::BFC_OP_COMPARE_WITH_BORROW) ||
                     (issue_op == bfc_pkg::BFC_OP_COMPARE_IMMEDIATE)))
      begin
        flag_we_q <= 1'b1;
        flag_q    <= cmp_status;
      end
      else if (fin && irq_exit_q)
      begin
        flag_we_q <= 1'b1;
        flag_q    <= status_in | (8'h01 << `BFC_FLG_I);
      end
    end
  end

  // ==========================================================
  // Outputs
  assign issue_ready = ready_q;
  assign pc          = pc_q;
  assign done        = done_q;
  assign flag_we     = flag_we_q;
  assign flag_out    = flag_q;
  assign push        = push_q;
  assign push_data   = push_data_q;
  assign pop         = pop_q;
endmodule : bfc_flow_unit
`default_nettype wire

// ### verification/bfc_flow_unit_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port checker
module bfc_flow_unit_asserts (
  input wire logic             clock,         // Core clock
  input wire logic             rst_n,         // Sync reset
  input wire logic             issue_valid,   // Offer
  input wire logic             issue_ready,   // Accept
  input wire bfc_pkg::bfc_op_e issue_op,      // Operation
  input wire logic [11:0]      issue_offset,  // Offset k
  input wire logic [15:0]      issue_addr,    // Absolute target
  input wire logic [7:0]       io_byte,       // I/O value
  input wire logic [2:0]       bit_sel,       // Bit index
  input wire logic [7:0]       status_in,     // Status byte
  input wire logic             next_two_word, // Long next
  input wire logic [15:0]      stack_rdata,   // Popped address
  input wire logic [15:0]      pc,            // Program counter
  input wire logic             done,          // Completion
  input wire logic             flag_we,       // Flag write
  input wire logic [7:0]       flag_out,      // New flags
  input wire logic             push,          // Push pulse
  input wire logic [15:0]      push_data,     // Pushed address
  input wire logic             pop            // Pop pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic        go;
  logic [15:0] k_q;
  assign go = issue_valid && issue_ready;
  // Offset kept sign extended so targets compare in full width
  always_ff @(posedge clock)
  begin
    k_q <= {{4{issue_offset[11]}}, issue_offset};
  end
  chk_compare_one: assert property (go && issue_op == bfc_pkg::BFC_OP_COMPARE_REGISTERS
    |=> done && flag_we && pc == $past(pc) + 16'h0001) else $error("compare timing wrong");
  chk_rel_jump: assert property (go && issue_op == bfc_pkg::BFC_OP_RELATIVE_JUMP
    |=> !issue_ready ##1 done && pc == $past(pc, 2) + $past(k_q) + 16'h0001)
    else $error("relative jump wrong");
  chk_abs_jump: assert property (go && issue_op == bfc_pkg::BFC_OP_ABSOLUTE_JUMP
    |=> !done [*2] ##1 done && pc == $past(issue_addr, 3)) else $error("absolute jump wrong");
  chk_invoke_push: assert property (go && issue_op == bfc_pkg::BFC_OP_RELATIVE_SUB_INVOKE
    |=> push && push_data == $past(pc) + 16'h0001 ##2 done) else $error("invoke push wrong");
  chk_exit_pop: assert property (go && issue_op == bfc_pkg::BFC_OP_SUBROUTINE_EXIT
    |=> pop ##1 !done [*2] ##1 done && pc == $past(stack_rdata)) else $error("exit wrong");
  chk_irq_exit: assert property (go && issue_op == bfc_pkg::BFC_OP_INTERRUPT_EXIT
    |-> ##4 done && flag_we && flag_out == ($past(status_in) | 8'h80))
    else $error("interrupt exit flags wrong");
  chk_branch_eq: assert property (go && issue_op == bfc_pkg::BFC_OP_BRANCH_EQUAL
    && status_in[1] |=> !issue_ready ##1 done && pc == $past(pc, 2) + $past(k_q) + 16'h0001)
    else $error("equal branch wrong");
  chk_half_nt: assert property (go && issue_op == bfc_pkg::BFC_OP_BRANCH_HALF_CARRY_SET
    && !status_in[5] |=> done && !flag_we && pc == $past(pc) + 16'h0001)
    else $error("half carry branch wrong");
  chk_skip_long: assert property (go && issue_op == bfc_pkg::BFC_OP_SKIP_IO_BIT_SET
    && io_byte[bit_sel] && next_two_word |=> !done ##1 !done ##1 done
    && pc == $past(pc, 3) + 16'h0003) else $error("long skip wrong");
  cover property (push);
  cover property (pop);
  cover property (go && issue_op == bfc_pkg::BFC_OP_BRANCH_EQUAL && status_in[1]);
endmodule : bfc_flow_unit_asserts
bind bfc_flow_unit bfc_flow_unit_asserts u_chk (
  .clock(clock), .rst_n(rst_n), .issue_valid(issue_valid), .issue_ready(issue_ready),
  .issue_op(issue_op), .issue_offset(issue_offset), .issue_addr(issue_addr),
  .io_byte(io_byte), .bit_sel(bit_sel), .status_in(status_in), .next_two_word(next_two_word),
  .stack_rdata(stack_rdata), .pc(pc), .done(done), .flag_we(flag_we), .flag_out(flag_out),
  .push(push), .push_data(push_data), .pop(pop));
`default_nettype wire

// ### verification/bfc_flow_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
module bfc_flow_unit_test;
  logic             clock = 1'b0, rst_n = 1'b0, issue_valid = 1'b0, next_two_word = 1'b0;
  bfc_pkg::bfc_op_e issue_op = bfc_pkg::BFC_OP_STEP;
  logic [11:0]      issue_offset = 12'h000;
  logic [15:0]      issue_addr = 16'h0000, z_ptr = 16'h0000, stack_rdata = 16'h0000;
  logic [7:0]       operand_a = 8'h00, operand_b = 8'h00, io_byte = 8'h00, status_in = 8'h00;
  logic [2:0]       bit_sel = 3'h0;
  logic [15:0]      pc, push_data, epc, pseen;
  logic [7:0]       flag_out, fseen = 8'h00;
  logic             issue_ready, done, flag_we, push, pop;
  int               miscompares = 0, n_checks = 0;
  bfc_flow_unit dut (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue_op(issue_op), .issue_offset(issue_offset), .issue_addr(issue_addr), .z_ptr(z_ptr),
    .operand_a(operand_a), .operand_b(operand_b), .io_byte(io_byte), .bit_sel(bit_sel),
    .status_in(status_in), .next_two_word(next_two_word), .stack_rdata(stack_rdata),
    .issue_ready(issue_ready), .pc(pc), .done(done), .flag_we(flag_we), .flag_out(flag_out),
    .push(push), .push_data(push_data), .pop(pop));
  always #10 clock = ~clock;
  always @(posedge clock) if (push === 1'b1) pseen <= push_data;
  always @(negedge clock) if (flag_we === 1'b1) fseen <= flag_out;
  // ==========================================================
  // Checking and issue
  task cmp_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) miscompares++;
    if (got !== exp) $display("[FAIL] %0t word %h expected %h", $time, got, exp);
  endtask : cmp_word
  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) miscompares++;
    if (got !== exp) $display("[FAIL] %0t flags %h expected %h", $time, got, exp);
  endtask : cmp_byte
  // Entered on a rising edge; returns on one, so drivers never collide
  task run(input bfc_pkg::bfc_op_e op, input logic [15:0] n_exp, input logic [15:0] nxt);
    logic [15:0] n;
    issue_op <= op;
    issue_valid <= 1'b1;
    @(posedge clock);
    issue_valid <= 1'b0;
    n = 16'h0001;
    #1;
    while (done !== 1'b1 && n < 16'h0008)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    cmp_word(n, n_exp);
    cmp_word(pc, nxt);
    epc = nxt;
    @(posedge clock);
  endtask : run
  // ==========================================================
  // Scenarios
  task t_jumps;
    issue_offset <= 12'hFFE;
    run(bfc_pkg::BFC_OP_RELATIVE_JUMP, 16'h0002, epc - 16'h0001);
    z_ptr <= 16'h1234;
    run(bfc_pkg::BFC_OP_POINTER_JUMP, 16'h0002, 16'h1234);
    issue_addr <= 16'hABCD;
    run(bfc_pkg::BFC_OP_ABSOLUTE_JUMP, 16'h0003, 16'hABCD);
    issue_offset <= 12'h7FF;
    run(bfc_pkg::BFC_OP_RELATIVE_JUMP, 16'h0002, epc + 16'h0800);
  endtask : t_jumps
  task t_invokes;
    logic [15:0] e;
    issue_offset <= 12'h010;
    run(bfc_pkg::BFC_OP_RELATIVE_SUB_INVOKE, 16'h0003, epc + 16'h0011);
    cmp_word(pseen, epc - 16'h0010);
    e = epc;
    z_ptr <= 16'h0400;
    run(bfc_pkg::BFC_OP_POINTER_SUB_INVOKE, 16'h0003, 16'h0400);
    cmp_word(pseen, e + 16'h0001);
    issue_addr <= 16'h2000;
    run(bfc_pkg::BFC_OP_ABSOLUTE_SUB_INVOKE, 16'h0004, 16'h2000);
    cmp_word(pseen, 16'h0402);
  endtask : t_invokes
  task t_exits;
    stack_rdata <= 16'h0123;
    run(bfc_pkg::BFC_OP_SUBROUTINE_EXIT, 16'h0004, 16'h0123);
    stack_rdata <= 16'h0456;
    status_in <= 8'h21;
    run(bfc_pkg::BFC_OP_INTERRUPT_EXIT, 16'h0004, 16'h0456);
    cmp_byte(fseen, 8'hA1);
  endtask : t_exits
  task cmp1(input bfc_pkg::bfc_op_e op, input logic [7:0] a, b, st, fx);
    operand_a <= a;
    operand_b <= b;
    status_in <= st;
    run(op, 16'h0001, epc + 16'h0001);
    cmp_byte(fseen, fx);
  endtask : cmp1
  task sk(input bfc_pkg::bfc_op_e op, input logic [7:0] a, b, io, input logic [2:0] bs,
          input logic tw, input logic [15:0] s);
    operand_a <= a;
    operand_b <= b;
    io_byte <= io;
    bit_sel <= bs;
    next_two_word <= tw;
    run(op, s, epc + s);
  endtask : sk
  // Expected branch outcome; codes follow the package encoding
  function logic tk(input logic [5:0] o, input logic [7:0] s);
    logic v;
    case (o)
      6'h11, 6'h12: v = s[o[2:0]];
      6'h13, 6'h14: v = s[1];
      6'h15, 6'h16, 6'h17, 6'h18: v = s[0];
      6'h19, 6'h1A: v = s[2];
      6'h1B, 6'h1C: v = s[2] ^ s[3];
      6'h1D, 6'h1E: v = s[5];
      6'h1F, 6'h20: v = s[6];
      6'h21, 6'h22: v = s[3];
      default: v = s[7];
    endcase
    return !(v ^ (o[0] ^ (o inside {6'h17, 6'h18, 6'h1B, 6'h1C})));
  endfunction : tk
  task t_branches;
    logic [7:0]  pat [4];
    logic [15:0] k;
    logic        t;
    pat = '{8'h00, 8'hFF, 8'h55, 8'hAA};
    for (int p = 0; p < 4; p++)
      for (logic [5:0] o = 6'h11; o <= 6'h24; o++)
      begin
        status_in <= pat[p];
        issue_offset <= {pat[p][3:0], 8'h01};
        bit_sel <= o[2:0];
        t = tk(o, pat[p]);
        k = t ? {{4{pat[p][3]}}, pat[p][3:0], 8'h02} : 16'h0001;
        run(bfc_pkg::bfc_op_e'(o), t ? 16'h0002 : 16'h0001, epc + k);
      end
  endtask : t_branches
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (8) @(posedge clock);
    cmp_word(pc, 16'h0000);
    cmp_word({15'h0000, issue_ready}, 16'h0001);
    rst_n <= 1'b1;
    epc = 16'h0000;
    t_jumps;
    t_invokes;
    t_exits;
    cmp1(bfc_pkg::BFC_OP_COMPARE_REGISTERS, 8'h10, 8'h20, 8'h00, 8'h15);
    cmp1(bfc_pkg::BFC_OP_COMPARE_WITH_BORROW, 8'h05, 8'h05, 8'h01, 8'h35);
    cmp1(bfc_pkg::BFC_OP_COMPARE_WITH_BORROW, 8'h05, 8'h05, 8'h02, 8'h02);
    cmp1(bfc_pkg::BFC_OP_COMPARE_WITH_BORROW, 8'h05, 8'h05, 8'h00, 8'h00);
    cmp1(bfc_pkg::BFC_OP_COMPARE_IMMEDIATE, 8'h80, 8'h01, 8'hC0, 8'hF8);
    sk(bfc_pkg::BFC_OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 8'h00, 3'h0, 1'b0, 16'h0002);
    sk(bfc_pkg::BFC_OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 8'h00, 3'h0, 1'b1, 16'h0003);
    sk(bfc_pkg::BFC_OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h34, 8'h00, 3'h0, 1'b1, 16'h0001);
    cmp_byte(fseen, 8'hF8);
    sk(bfc_pkg::BFC_OP_SKIP_REG_BIT_CLEAR, 8'hF7, 8'h00, 8'h00, 3'h3, 1'b0, 16'h0002);
    sk(bfc_pkg::BFC_OP_SKIP_REG_BIT_SET, 8'hF7, 8'h00, 8'h00, 3'h3, 1'b0, 16'h0001);
    sk(bfc_pkg::BFC_OP_SKIP_REG_BIT_SET, 8'h08, 8'h00, 8'h00, 3'h3, 1'b1, 16'h0003);
    sk(bfc_pkg::BFC_OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'hFE, 3'h0, 1'b0, 16'h0002);
    sk(bfc_pkg::BFC_OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 8'hFE, 3'h0, 1'b1, 16'h0001);
    sk(bfc_pkg::BFC_OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 8'h80, 3'h7, 1'b1, 16'h0003);
    t_branches;
    complete_run;
  end
  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    miscompares++;
    complete_run;
  end
endmodule : bfc_flow_unit_test
`default_nettype wire
